// file: flag_clear.sv
/*
  Raw flag register, abort reason register and read-to-clear decode.
  Assumes events and levels arrive synchronous to clk_in; the read
  strobe is one cycle per access.
*/
`timescale 1ns/1ps
`default_nettype none

module flag_clear (
  input  wire logic                                     clk_in,
  input  wire logic                                     nrst_in,
  input  wire logic                                     rd_in,
  input  wire logic [31:0]                              addr_in,
  output logic      [flag_clear_pkg::data_width-1:0]    rdata_out,
  input  wire flag_clear_pkg::event_t                   event_in,
  input  wire flag_clear_pkg::level_t                   level_in,
  input  wire logic                                     enable_in,
  input  wire logic                                     active_in,
  input  wire logic                                     read_served_in,
  output logic      [flag_clear_pkg::raw_width-1:0]     raw_flags_out,
  output logic      [flag_clear_pkg::reason_width-1:0]  abort_reason_out,
  output logic                                          combined_flag_out,
  output logic                                          tx_flush_out,
  output logic                                          scl_hold_out
);

  logic                                     rst_meta;
  logic                                     rst_sync_n;
  logic [flag_clear_pkg::raw_width-1:0]     raw;
  logic [flag_clear_pkg::reason_width-1:0]  reason;
  logic                                     idle_off;
  logic                                     under_flag;
  logic                                     over_flag;
  logic                                     full_flag;
  logic                                     tx_over_flag;
  logic                                     empty_flag;
  logic                                     request_flag;
  logic                                     abort_flag;
  logic                                     done_flag;
  logic                                     activity_flag;
  logic                                     stop_flag;
  logic [1:0]                               upper_flags;
  logic [flag_clear_pkg::raw_width-1:0]     clr;
  logic                                     clr_all;
  logic                                     clr_reason;
  logic [flag_clear_pkg::data_width-1:0]    next_rdata;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] r);
    hit = (a == r);
  endfunction

  // Set wins over clear in the same cycle
  function automatic logic flag_step(input logic cur, input logic set, input logic clear);
    flag_step = set || (cur && !clear);
  endfunction

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Clear decode, acts in the read cycle
  always_comb
  begin
    clr = '0;
    clr_all = rd_in && hit(addr_in, flag_clear_pkg::global_flag_clear_addr);
    if (clr_all)
      clr = flag_clear_pkg::soft_mask;
    else if (rd_in && hit(addr_in, flag_clear_pkg::receive_underflow_clear_addr))
      clr[flag_clear_pkg::rx_under_bit] = 1'b1;
    else if (rd_in && hit(addr_in, flag_clear_pkg::receive_overflow_clear_addr))
      clr[flag_clear_pkg::rx_over_bit] = 1'b1;
    else if (rd_in && hit(addr_in, flag_clear_pkg::transmit_overflow_clear_addr))
      clr[flag_clear_pkg::tx_over_bit] = 1'b1;
    else if (rd_in && hit(addr_in, flag_clear_pkg::read_request_clear_addr))
      clr[flag_clear_pkg::rd_req_bit] = 1'b1;
    else if (rd_in && hit(addr_in, flag_clear_pkg::transmit_abort_clear_addr))
      clr[flag_clear_pkg::tx_abort_bit] = 1'b1;
    else if (rd_in && hit(addr_in, flag_clear_pkg::receive_done_clear_addr))
      clr[flag_clear_pkg::rx_done_bit] = 1'b1;
    else if (rd_in && hit(addr_in, flag_clear_pkg::bus_activity_clear_addr))
      clr[flag_clear_pkg::activity_bit] = 1'b1;
    else if (rd_in && hit(addr_in, flag_clear_pkg::stop_condition_seen_clear_addr))
      clr[flag_clear_pkg::stop_seen_bit] = 1'b1;
    clr_reason = clr[flag_clear_pkg::tx_abort_bit]
                 && !reason[flag_clear_pkg::abort_keep_bit];
  end

  // Disabled and idle: receive underflow/overflow, transmit overflow and activity flags drop on their own
  assign idle_off = !enable_in && !active_in;

  // Receive underflow flag
  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      under_flag <= flag_clear_pkg::raw_reset[flag_clear_pkg::rx_under_bit];
    end
    else
    begin
      under_flag <= flag_step(under_flag, event_in.set[flag_clear_pkg::rx_under_bit],
        clr[flag_clear_pkg::rx_under_bit] || idle_off);
    end
  end

  // Receive overflow flag
  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      over_flag <= flag_clear_pkg::raw_reset[flag_clear_pkg::rx_over_bit];
    end
    else
    begin
      over_flag <= flag_step(over_flag, event_in.set[flag_clear_pkg::rx_over_bit],
        clr[flag_clear_pkg::rx_over_bit] || idle_off);
    end
  end

  // Transmit overflow flag
  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      tx_over_flag <= flag_clear_pkg::raw_reset[flag_clear_pkg::tx_over_bit];
    end
    else
    begin
      tx_over_flag <= flag_step(tx_over_flag, event_in.set[flag_clear_pkg::tx_over_bit],
        clr[flag_clear_pkg::tx_over_bit] || idle_off);
    end
  end

  // Remote read request flag
  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      request_flag <= flag_clear_pkg::raw_reset[flag_clear_pkg::rd_req_bit];
    end
    else
    begin
      request_flag <= flag_step(request_flag, event_in.set[flag_clear_pkg::rd_req_bit],
        clr[flag_clear_pkg::rd_req_bit]);
    end
  end

  // Transmit abort flag, also holds the transmit buffer flushed
  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      abort_flag <= flag_clear_pkg::raw_reset[flag_clear_pkg::tx_abort_bit];
    end
    else
    begin
      abort_flag <= flag_step(abort_flag, event_in.set[flag_clear_pkg::tx_abort_bit],
        clr[flag_clear_pkg::tx_abort_bit]);
    end
  end

  // Receive done flag
  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      done_flag <= flag_clear_pkg::raw_reset[flag_clear_pkg::rx_done_bit];
    end
    else
    begin
      done_flag <= flag_step(done_flag, event_in.set[flag_clear_pkg::rx_done_bit],
        clr[flag_clear_pkg::rx_done_bit]);
    end
  end

  // Stop condition flag
  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      stop_flag <= flag_clear_pkg::raw_reset[flag_clear_pkg::stop_seen_bit];
    end
    else
    begin
      stop_flag <= flag_step(stop_flag, event_in.set[flag_clear_pkg::stop_seen_bit],
        clr[flag_clear_pkg::stop_seen_bit]);
    end
  end

  // Activity flag: busy bus keeps it set through a clear
  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      activity_flag <= flag_clear_pkg::raw_reset[flag_clear_pkg::activity_bit];
    end
    else
    begin
      activity_flag <= flag_step(activity_flag,
        event_in.set[flag_clear_pkg::activity_bit] || active_in,
        clr[flag_clear_pkg::activity_bit] || idle_off);
    end
  end

  // Receive threshold level, dropped while disabled
  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      full_flag <= flag_clear_pkg::raw_reset[flag_clear_pkg::rx_full_bit];
    end
    else
    begin
      full_flag <= level_in.rx_full && enable_in;
    end
  end

  // Transmit threshold level
  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      empty_flag <= flag_clear_pkg::raw_reset[flag_clear_pkg::tx_empty_bit];
    end
    else
    begin
      empty_flag <= level_in.tx_empty;
    end
  end

  // Upper raw bits, set only, cleared by reset
  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      upper_flags <=
        flag_clear_pkg::raw_reset[flag_clear_pkg::raw_width-1:flag_clear_pkg::stop_seen_bit+1];
    end
    else
    begin
      upper_flags <= upper_flags |
        event_in.set[flag_clear_pkg::raw_width-1:flag_clear_pkg::stop_seen_bit+1];
    end
  end

  // Abort reason, kept while its keep bit is set
  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      reason <= flag_clear_pkg::reason_reset;
    end
    else
    begin
      reason <= (clr_reason ? flag_clear_pkg::reason_reset : reason) |
        event_in.reason;
    end
  end

  // Raw status word from the individual flags
  always_comb
  begin
    raw = flag_clear_pkg::raw_reset;
    raw[flag_clear_pkg::rx_under_bit]  = under_flag;
    raw[flag_clear_pkg::rx_over_bit]   = over_flag;
    raw[flag_clear_pkg::rx_full_bit]   = full_flag;
    raw[flag_clear_pkg::tx_over_bit]   = tx_over_flag;
    raw[flag_clear_pkg::tx_empty_bit]  = empty_flag;
    raw[flag_clear_pkg::rd_req_bit]    = request_flag;
    raw[flag_clear_pkg::tx_abort_bit]  = abort_flag;
    raw[flag_clear_pkg::rx_done_bit]   = done_flag;
    raw[flag_clear_pkg::activity_bit]  = activity_flag;
    raw[flag_clear_pkg::stop_seen_bit] = stop_flag;
    raw[flag_clear_pkg::raw_width-1:flag_clear_pkg::stop_seen_bit+1] = upper_flags;
  end

  // Read data: only the activity clear returns status
  always_comb
  begin
    next_rdata = flag_clear_pkg::data_reset;
    if (rd_in && hit(addr_in, flag_clear_pkg::bus_activity_clear_addr))
      next_rdata[0] = raw[flag_clear_pkg::activity_bit];
  end

  always_ff @(posedge clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      rdata_out <= flag_clear_pkg::data_reset;
    else
      rdata_out <= next_rdata;
  end

  assign raw_flags_out     = raw;
  assign abort_reason_out  = reason;
  assign combined_flag_out = |raw;
  assign tx_flush_out      = raw[flag_clear_pkg::tx_abort_bit] || !enable_in;
  assign scl_hold_out      = raw[flag_clear_pkg::rd_req_bit] && !read_served_in;

endmodule

`default_nettype wire

// file: flag_clear_pkg.sv
/*
  Constants and types for the read-to-clear flag logic of a two-wire serial controller.
  Assumes a simple peripheral read port with a one-cycle read strobe.

*/

package flag_clear_pkg;

  localparam logic [31:0] global_flag_clear_addr       = 32'h5000_1440;
  localparam logic [31:0] receive_underflow_clear_addr = 32'h5000_1444;
  localparam logic [31:0] receive_overflow_clear_addr  = 32'h5000_1448;
  localparam logic [31:0] transmit_overflow_clear_addr = 32'h5000_144c;
  localparam logic [31:0] read_request_clear_addr      = 32'h5000_1450;
  localparam logic [31:0] transmit_abort_clear_addr    = 32'h5000_1454;
  localparam logic [31:0] receive_done_clear_addr      = 32'h5000_1458;
  localparam logic [31:0] bus_activity_clear_addr      = 32'h5000_145c;
  localparam logic [31:0] stop_condition_seen_clear_addr = 32'h5000_1460;

  localparam int rx_under_bit  = 0;
  localparam int rx_over_bit   = 1;
  localparam int rx_full_bit   = 2;
  localparam int tx_over_bit   = 3;
  localparam int tx_empty_bit  = 4;
  localparam int rd_req_bit    = 5;
  localparam int tx_abort_bit  = 6;
  localparam int rx_done_bit   = 7;
  localparam int activity_bit  = 8;
  localparam int stop_seen_bit = 9;
  localparam int abort_keep_bit = 9;

  localparam int raw_width    = 12;
  localparam int reason_width = 16;
  localparam int data_width   = 16;

  localparam logic [raw_width-1:0]    raw_reset    = 12'h000;
  localparam logic [reason_width-1:0] reason_reset = 16'h0000;
  localparam logic [data_width-1:0]   data_reset   = 16'h0000;

  // Soft-clearable raw flags (threshold flags and upper bits 10-11 excluded)
  localparam logic [raw_width-1:0] soft_mask = 12'h3eb;

  typedef struct packed {
    logic [raw_width-1:0] set;
    logic [reason_width-1:0] reason;
  } event_t;

  typedef struct packed {
    logic rx_full;
    logic tx_empty;
  } level_t;

endpackage

// file: bus_peer.sv
/*
  Remote bus party: keeps the controller busy while a transfer runs.
  Assumes the bench requests transfers on the falling clock edge.
*/
`timescale 1ns/1ps
`default_nettype none
module bus_peer (
  input  wire logic clk_in,
  input  wire logic busy_in,
  output logic      active_out
);
  initial active_out = 1'b0;
  // Busy from the first rising edge after the request
  always @(posedge clk_in)
    active_out <= busy_in;
endmodule
`default_nettype wire

// file: flag_clear_assertions.sv
/*
  Port checker for flag_clear.
  Assumes the bind below and one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module flag_clear_chk (
  input wire logic                   clk_in,
  input wire logic                   nrst_in,
  input wire logic                   rd_in,
  input wire logic                   enable_in,
  input wire logic                   active_in,
  input wire logic [31:0]            addr_in,
  input wire logic [15:0]            rdata_out,
  input wire logic [15:0]            abort_reason_out,
  input wire logic [11:0]            raw_flags_out,
  input wire flag_clear_pkg::event_t event_in,
  input wire logic                   tx_flush_out,
  input wire logic                   scl_hold_out
);
  logic [7:0] lo;
  wire  [11:0] s = event_in.set;
  assign lo = (rd_in && addr_in[31:8] == 24'h500014) ? addr_in[7:0] : 8'h00;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_underflow_clear: assert property (lo == 8'h44 && !s[0] |=> !raw_flags_out[0])
    else $error("underflow kept");
  a_request_clear: assert property (lo == 8'h50 && !s[5] |=> !raw_flags_out[5])
    else $error("request kept");
  a_abort_clear: assert property (lo == 8'h54 && !s[6] && event_in.reason == 16'h0000
    && !abort_reason_out[9] |=> !raw_flags_out[6] && abort_reason_out == 16'h0000)
    else $error("abort kept");
  a_global_clear: assert property (lo == 8'h40 && s == 12'h000 && !active_in
    |=> (raw_flags_out & 12'h3eb) == 12'h000) else $error("global clear missed");
  a_busy_keeps: assert property (lo == 8'h5c && active_in && raw_flags_out[8]
    |=> raw_flags_out[8]) else $error("activity lost");
  a_idle_autoclear: assert property (!enable_in && !active_in && !s[8]
    |=> !raw_flags_out[8]) else $error("activity stuck");
  a_activity_read: assert property (lo == 8'h5c
    |=> rdata_out == {15'h0000, $past(raw_flags_out[8])}) else $error("activity read");
  a_flush_level: assert property (tx_flush_out == (raw_flags_out[6] || !enable_in))
    else $error("flush wrong");
  a_stretch_cause: assert property (scl_hold_out |-> raw_flags_out[5])
    else $error("hold without request");
endmodule
bind flag_clear flag_clear_chk CHK (.*);
`default_nettype wire

// file: flag_clear_bench.sv
/*
  Bench for flag_clear: clear reads checked against raw flags.
  Assumes the checker and bus_peer are compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,g) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module flag_clear_bench;
  logic clk_in = 0, nrst_in = 0, rd_in = 0, enable_in = 1, busy = 0, served = 0;
  logic active, comb, flush, hold;
  logic [31:0] addr_in = 32'h0;
  logic [15:0] rdata, reason;
  logic [11:0] raw, exp;
  flag_clear_pkg::event_t ev = '0;
  flag_clear_pkg::level_t lv = '0;
  int bad_count = 0, compares = 0;
  int bits [7] = '{0, 1, 3, 5, 6, 7, 8};
  always #50 clk_in = ~clk_in;
  bus_peer PEER (.clk_in(clk_in), .busy_in(busy), .active_out(active));
  flag_clear DUT (.clk_in(clk_in), .nrst_in(nrst_in), .rd_in(rd_in), .addr_in(addr_in),
    .rdata_out(rdata), .event_in(ev), .level_in(lv), .enable_in(enable_in),
    .active_in(active), .read_served_in(served), .raw_flags_out(raw),
    .abort_reason_out(reason), .combined_flag_out(comb), .tx_flush_out(flush),
    .scl_hold_out(hold));
  task automatic rd(input logic [31:0] a, input logic [15:0] d);
    @(negedge clk_in);
    rd_in = 1;
    addr_in = a;
    @(negedge clk_in);
    rd_in = 0;
    `CHK("rdata", d, rdata)
  endtask
  task automatic fire(input logic [11:0] s, input logic [15:0] r);
    @(negedge clk_in);
    ev = {s, r};
    @(negedge clk_in);
    ev = '0;
  endtask
  task automatic print_verdict;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge clk_in);
    nrst_in = 1;
    repeat (3) @(negedge clk_in);
    for (int i = 0; i < 9; i++) rd(32'h5000_1440 + 4 * i, 16'h0000);
    `CHK("raw", 12'h000, raw)
    $display("reset test done");
    fire(12'h3eb, 16'h0000);
    exp = 12'h3eb;
    `CHK("flush", 1'b1, flush)
    `CHK("hold", 1'b1, hold)
    `CHK("comb", 1'b1, comb)
    served = 1;
    @(negedge clk_in);
    `CHK("hold", 1'b0, hold)
    served = 0;
    rd(32'h5000_1500, 16'h0000);
    for (int i = 0; i < 7; i++)
    begin
      exp[bits[i]] = 1'b0;
      rd(32'h5000_1444 + 4 * i, {15'h0000, i == 6});
      `CHK("raw", exp, raw)
    end
    `CHK("flush", 1'b0, flush)
    `CHK("hold", 1'b0, hold)
    $display("single clear test done");
    fire(12'h040, 16'h0201);
    rd(32'h5000_1454, 16'h0000);
    `CHK("reason", 16'h0201, reason)
    `CHK("raw", 12'h200, raw)
    busy = 1;
    fire(12'h100, 16'h0000);
    rd(32'h5000_145c, 16'h0001);
    `CHK("raw", 12'h300, raw)
    lv.rx_full = 1;
    fire(12'h0ab, 16'h0000);
    rd(32'h5000_1440, 16'h0000);
    `CHK("raw", 12'h104, raw)
    `CHK("reason", 16'h0201, reason)
    $display("global clear test done");
    lv.rx_full = 0;
    busy = 0;
    enable_in = 0;
    repeat (3) @(negedge clk_in);
    `CHK("raw", 12'h000, raw)
    `CHK("comb", 1'b0, comb)
    `CHK("flush", 1'b1, flush)
    fire(12'h200, 16'h0000);
    `CHK("raw", 12'h200, raw)
    rd(32'h5000_1460, 16'h0000);
    `CHK("raw", 12'h000, raw)
    $display("idle test done");
    print_verdict;
  end
  initial
  begin
    #100us;
    bad_count++;
    print_verdict;
  end
endmodule
`default_nettype wire
